// ### verilog/fault_log_pkg.sv
// package: constants and carrier types for the fault log integrity guard
package fault_log_pkg;

	localparam int          LOG_DEPTH       = 16;
	localparam int          LOG_AW          = 4;
	localparam int          CLK_HZ          = 40000000;
	localparam int          ERASE_MS        = 160;
	// erase time in cycles: 160 ms at 40 MHz
	localparam int          ERASE_CYCLES    = (CLK_HZ / 1000) * ERASE_MS;
	localparam logic [7:0]  BOOT_MODE_CODE  = 8'hd9;
	localparam logic [15:0] CSUM_RESET      = 16'hffff;
	localparam logic [15:0] CSUM_POLY       = 16'h1021;
	localparam logic [31:0] ERASED_WORD     = 32'hffffffff;

	// one fault entry appended by the sequencer
	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} log_wr_t;

	// host read request and answer
	typedef struct packed {
		logic              valid;
		logic [LOG_AW-1:0] addr;
	} log_rd_req_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} log_rd_rsp_t;

	// one byte seen on the management bus by the protocol front end
	typedef struct packed {
		logic       valid;
		logic       first;   // command byte of a packet
		logic       last;    // stop condition follows this byte
		logic [7:0] data;
	} bus_byte_t;

endpackage

// ### verilog/pec_cmd_filter.sv
// module: boot-mode command detection with automatic pec handling
`timescale 1ns/1ps

module pec_cmd_filter
	import fault_log_pkg::*;
(
	input  wire logic      core_clk,
	input  wire logic      sys_rst,
	input  wire bus_byte_t bus_byte,
	output logic           boot_cmd,
	output logic           pec_used
);

	// crc-8 step with polynomial x^8+x^2+x+1, used for pec bytes
	function automatic logic [7:0] crc8(input logic [7:0] c,
		input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
		end
		return r;
	endfunction

	logic [7:0] crc_ff;
	logic [7:0] nxt_crc;
	logic [2:0] cnt_ff;
	logic [2:0] nxt_cnt;
	logic       boot_ff;
	logic       nxt_boot;
	logic       cmd_ff;
	logic       nxt_cmd;
	logic       pec_ff;
	logic       nxt_pec;

	// a packet of one byte is a send-byte; two bytes whose second matches
	// the running crc is the same command carrying pec; a bad pec drops it
	always_comb begin
		nxt_crc      = crc_ff;
		nxt_cnt      = cnt_ff;
		nxt_cmd      = cmd_ff;
		nxt_boot     = 1'b0;
		nxt_pec      = pec_ff;
		if (bus_byte.valid) begin
			if (bus_byte.first) begin
				nxt_crc      = crc8(8'h00, bus_byte.data);
				nxt_cnt      = 3'h1;
				nxt_cmd      = (bus_byte.data == BOOT_MODE_CODE);
			end else begin
				nxt_crc      = crc8(crc_ff, bus_byte.data);
				nxt_cnt      = (cnt_ff == 3'h7) ? cnt_ff : cnt_ff + 3'h1;
			end
			if (bus_byte.last) begin
				if (bus_byte.first) begin
					nxt_boot = bus_byte.data == BOOT_MODE_CODE;
					// pec flag follows only an accepted boot packet
					if (bus_byte.data == BOOT_MODE_CODE) begin
						nxt_pec = 1'b0;
					end
				end else if (cnt_ff == 3'h1 && cmd_ff &&
					bus_byte.data == crc_ff) begin
					nxt_boot = 1'b1;
					nxt_pec  = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			crc_ff      <= 8'h00;
			cnt_ff      <= 3'h0;
			cmd_ff      <= 1'b0;
			boot_ff     <= 1'b0;
			pec_ff      <= 1'b0;
		end else begin
			crc_ff      <= nxt_crc;
			cnt_ff      <= nxt_cnt;
			cmd_ff      <= nxt_cmd;
			boot_ff     <= nxt_boot;
			pec_ff      <= nxt_pec;
		end
	end

	assign boot_cmd = boot_ff;
	assign pec_used = pec_ff;

endmodule

// ### verilog/fault_log_integrity_guard.sv
// module: checksum-protected fault log with start-up check and erase
//
// Overview of operation
// - update stored checksum after each log append, except one whose write edge meets sys_rst
// - recompute and compare checksum after every reset
// - mismatch means corrupt log: erase it all
// - erase lengthens start-up by about 160 ms
// - command d9 enters boot-loader mode, sequencing stops
// - accept bus packets with or without pec
`timescale 1ns/1ps

module fault_log_integrity_guard
	import fault_log_pkg::*;
#(
	// erase wait in cycles; the default is the real flash erase time,
	// a simulation passes a short value so that a run stays small
	parameter int ERASE_CNT = ERASE_CYCLES
)(
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire log_wr_t     log_wr,
	output logic             log_wr_ready,
	input  wire log_rd_req_t log_rd_req,
	output logic             log_rd_ready,
	output log_rd_rsp_t      log_rd_rsp,
	input  wire bus_byte_t   bus_byte,
	output logic             init_done,
	output logic             log_erased,
	output logic             boot_mode,
	output logic             seq_enable,
	output logic             pec_seen,
	output logic [LOG_AW:0]  log_count
);

	// check walks the stored entries, compare keeps or condemns the log,
	// erase clears the array in one cycle and wait covers its flash time
	typedef enum logic [2:0] {
		ST_CHECK,
		ST_COMPARE,
		ST_ERASE,
		ST_WAIT,
		ST_RUN
	} state_t;

	// crc-16 ccitt over one 32-bit word
	function automatic logic [15:0] csum_word(input logic [15:0] c,
		input logic [31:0] w);
		logic [15:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			r = (r[15] ^ w[i]) ? ((r << 1) ^ CSUM_POLY) : (r << 1);
		end
		return r;
	endfunction

	// flash array, stored checksum and fill count survive sys_rst,
	// as flash survives a device reset
	logic [31:0]       mem_ff [LOG_DEPTH];
	logic [15:0]       stored_csum_ff;
	logic [LOG_AW:0]   count_ff;

	// control state: rebuilt from scratch after every reset
	state_t            state_ff;
	state_t            nxt_state;
	logic [15:0]       calc_ff;
	logic [15:0]       nxt_calc;
	logic [LOG_AW:0]   idx_ff;
	logic [LOG_AW:0]   nxt_idx;
	logic [31:0]       timer_ff;
	logic [31:0]       nxt_timer;
	logic              erased_ff;
	logic              nxt_erased;
	logic              boot_ff;
	logic              nxt_boot;
	log_rd_rsp_t       rsp_ff;
	log_rd_rsp_t       nxt_rsp;
	logic              boot_cmd;
	logic              do_append;
	logic              in_run;

	pec_cmd_filter u_pec_cmd_filter (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.bus_byte (bus_byte),
		.boot_cmd (boot_cmd),
		.pec_used (pec_seen)
	);

	// the log is usable only once the start-up check has settled
	assign in_run       = (state_ff == ST_RUN);

	// appends only in run state and while room remains; full log stalls
	assign log_wr_ready = in_run && !boot_ff &&
		(count_ff < LOG_DEPTH[LOG_AW:0]);
	assign do_append    = log_wr.valid && log_wr_ready;
	assign log_rd_ready = in_run;

	// start-up check sequence and run-time controls
	always_comb begin
		nxt_state  = state_ff;
		nxt_calc   = calc_ff;
		nxt_idx    = idx_ff;
		nxt_timer  = timer_ff;
		nxt_erased = erased_ff;
		nxt_boot   = boot_ff;
		nxt_rsp    = '0;
		case (state_ff)
			ST_CHECK: begin
				// walk every filled entry through the checksum
				if (idx_ff < count_ff) begin
					nxt_calc = csum_word(calc_ff,
						mem_ff[idx_ff[LOG_AW-1:0]]);
					nxt_idx  = idx_ff + 1'b1;
				end else begin
					nxt_state = ST_COMPARE;
				end
			end
			ST_COMPARE: begin
				// blank or torn flash reads as unknown or wrong; only an
				// exact match with a plausible fill count keeps the log
				if (calc_ff == stored_csum_ff &&
					count_ff <= LOG_DEPTH[LOG_AW:0]) begin
					nxt_state = ST_RUN;
				end else begin
					nxt_state  = ST_ERASE;
					nxt_erased = 1'b1;
					nxt_idx    = '0;
				end
			end
			ST_ERASE: begin
				// array is cleared in this cycle, the wait covers flash time
				nxt_state = ST_WAIT;
				nxt_timer = '0;
			end
			ST_WAIT: begin
				// models flash erase time before the log is usable
				if (timer_ff >= ERASE_CNT - 1) begin
					nxt_state = ST_RUN;
				end else begin
					nxt_timer = timer_ff + 32'h1;
				end
			end
			ST_RUN: begin
				// appends fold into the running checksum, so the stored
				// and running copies stay equal without a fresh walk
				if (do_append) begin
					nxt_calc = csum_word(calc_ff, log_wr.data);
				end
				// reads outside run get no answer at all
				if (log_rd_req.valid) begin
					nxt_rsp.valid = 1'b1;
					nxt_rsp.data  = (log_rd_req.addr < count_ff) ?
						mem_ff[log_rd_req.addr] : ERASED_WORD;
				end
				// a boot packet outside run is dropped, not queued
				if (boot_cmd) begin
					nxt_boot = 1'b1;
				end
			end
			default: begin
				nxt_state = ST_CHECK;
			end
		endcase
		// running checksum restarts together with the emptied log
		if (state_ff == ST_ERASE) begin
			nxt_calc = CSUM_RESET;
		end
	end

	// control state restarts on every reset; the check starts over
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_ff  <= ST_CHECK;
			calc_ff   <= CSUM_RESET;
			idx_ff    <= '0;
			timer_ff  <= 32'h0;
			erased_ff <= 1'b0;
			boot_ff   <= 1'b0;
			rsp_ff    <= '0;
		end else begin
			state_ff  <= nxt_state;
			calc_ff   <= nxt_calc;
			idx_ff    <= nxt_idx;
			timer_ff  <= nxt_timer;
			erased_ff <= nxt_erased;
			boot_ff   <= nxt_boot;
			rsp_ff    <= nxt_rsp;
		end
	end

	// nonvolatile side: entry write, checksum store, whole-log erase.
	// no reset here: contents persist across sys_rst like flash. an entry
	// whose write edge meets sys_rst still lands, but its checksum does
	// not; that torn write is what the start-up check must catch
	always_ff @(posedge core_clk) begin
		if (!sys_rst && state_ff == ST_ERASE) begin
			count_ff       <= '0;
			stored_csum_ff <= CSUM_RESET;
			for (int i = 0; i < LOG_DEPTH; i++) begin
				mem_ff[i] <= ERASED_WORD;
			end
		end else if (do_append) begin
			mem_ff[count_ff[LOG_AW-1:0]] <= log_wr.data;
			count_ff       <= count_ff + 1'b1;
			if (!sys_rst) begin
				stored_csum_ff <= csum_word(calc_ff, log_wr.data);
			end
		end
	end

	// status outputs; sequencing stops once boot mode is taken, until the next sys_rst clears it
	assign init_done  = in_run;
	assign log_erased = erased_ff;
	assign boot_mode  = boot_ff;
	assign seq_enable = in_run && !boot_ff;
	assign log_rd_rsp = rsp_ff;
	assign log_count  = count_ff;

endmodule

// ### testbench/host_bus_model.sv
// host side: sends one command packet per start pulse
`timescale 1ns/1ps
module host_bus_model
	import fault_log_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       start,
	input  wire logic       with_pec,
	input  wire logic       bad_pec,
	input  wire logic [7:0] cmd,
	output bus_byte_t       bus_byte
);
	logic pend_ff = 1'b0;
	initial bus_byte = '0;
	// pec is crc8 poly 07, init 0, over the command byte
	function automatic logic [7:0] crc8(input logic [7:0] b);
		logic [7:0] c;
		c = b;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
		end
		return c;
	endfunction
	// idle bytes show inverted data so stale values never look valid
	always @(posedge core_clk) begin
		pend_ff <= start && with_pec;
		if (start) begin
			bus_byte <= {1'b1, 1'b1, !with_pec, cmd};
		end else if (pend_ff) begin
			bus_byte <= {3'b101, crc8(cmd) ^ {7'h00, bad_pec}};
		end else begin
			bus_byte <= {3'b000, ~bus_byte.data};
		end
	end
endmodule

// ### testbench/fault_log_guard_monitor.sv
// checker: port properties of the fault log guard
`timescale 1ns/1ps
module fault_log_guard_monitor
	import fault_log_pkg::*;
#(
	parameter int ERASE_CNT = 20
)(
	input wire logic        core_clk,
	input wire logic        sys_rst,
	input wire log_wr_t     log_wr,
	input wire logic        log_wr_ready,
	input wire log_rd_req_t log_rd_req,
	input wire log_rd_rsp_t log_rd_rsp,
	input wire logic        init_done,
	input wire logic        log_erased,
	input wire logic        boot_mode,
	input wire logic        seq_enable,
	input wire logic [4:0]  log_count
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	chk_append_count: assert property (
		log_wr.valid && log_wr_ready |=> log_count == $past(log_count) + 5'h01)
		else $error("append did not advance count");
	chk_check_first: assert property (
		$fell(sys_rst) |-> !init_done) else $error("run without check");
	chk_erase_empty: assert property (
		$rose(init_done) && log_erased |-> log_count == 5'h00)
		else $error("erased log not empty");
	chk_erase_wait: assert property (
		$rose(init_done) && log_erased |-> !$past(init_done, ERASE_CNT))
		else $error("erase wait too short");
	chk_boot_stops: assert property (
		boot_mode |-> !seq_enable && !log_wr_ready)
		else $error("sequencing in boot mode");
	chk_boot_sticky: assert property (
		boot_mode |=> boot_mode) else $error("boot mode dropped");
	chk_read_gated: assert property (
		log_rd_rsp.valid |-> $past(log_rd_req.valid) && $past(init_done))
		else $error("read answer outside run");
	chk_read_answer: assert property (
		log_rd_req.valid && init_done |=> log_rd_rsp.valid)
		else $error("read not answered");
endmodule
bind fault_log_integrity_guard fault_log_guard_monitor
	#(.ERASE_CNT(ERASE_CNT)) u_mon (
	.core_clk     (core_clk),
	.sys_rst      (sys_rst),
	.log_wr       (log_wr),
	.log_wr_ready (log_wr_ready),
	.log_rd_req   (log_rd_req),
	.log_rd_rsp   (log_rd_rsp),
	.init_done    (init_done),
	.log_erased   (log_erased),
	.boot_mode    (boot_mode),
	.seq_enable   (seq_enable),
	.log_count    (log_count)
);

// ### testbench/test_fault_log_integrity_guard.sv
// testbench: appends, restarts, erase and boot command
`timescale 1ns/1ps
module test_fault_log_integrity_guard;
	import fault_log_pkg::*;
	logic        core_clk = 0;
	logic        sys_rst = 1;
	log_wr_t     log_wr = '0;
	log_rd_req_t log_rd_req = '0;
	log_rd_rsp_t log_rd_rsp;
	bus_byte_t   bus_byte;
	logic        log_wr_ready, log_rd_ready, init_done, log_erased;
	logic        boot_mode, seq_enable, pec_seen;
	logic        go = 0, pec = 0, bad = 0;
	logic [7:0]  cmd = '0, c;
	logic [4:0]  log_count;
	logic [31:0] img [16];
	int          n_errors = 0, check_count = 0, cyc = 0, n = 0, w;
	initial forever #12.5 core_clk = ~core_clk;
	fault_log_integrity_guard #(.ERASE_CNT(20)) u_fault_log_integrity_guard (
		.core_clk     (core_clk),
		.sys_rst      (sys_rst),
		.log_wr       (log_wr),
		.log_wr_ready (log_wr_ready),
		.log_rd_req   (log_rd_req),
		.log_rd_ready (log_rd_ready),
		.log_rd_rsp   (log_rd_rsp),
		.bus_byte     (bus_byte),
		.init_done    (init_done),
		.log_erased   (log_erased),
		.boot_mode    (boot_mode),
		.seq_enable   (seq_enable),
		.pec_seen     (pec_seen),
		.log_count    (log_count)
	);
	host_bus_model u_host_bus_model (
		.core_clk (core_clk),
		.start    (go),
		.with_pec (pec),
		.bad_pec  (bad),
		.cmd      (cmd),
		.bus_byte (bus_byte)
	);
	// hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_errors++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
		check_count++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tk(int k = 1);
		repeat (k) @(posedge core_clk);
	endtask
	// reset only between appends, never mid-program
	task automatic rst_wait();
		tk();
		sys_rst <= 1;
		tk(2);
		sys_rst <= 0;
		tk();
		#1 chk("rd_gate", log_rd_ready, 0);
		w = 1;
		while (init_done !== 1'b1 && w < 300) begin
			tk();
			#1 w++;
		end
		chk("init", init_done, 1);
		chk("rd_open", log_rd_ready, 1);
	endtask
	task automatic rd(int a, logic [31:0] e);
		tk();
		log_rd_req <= {1'b1, a[3:0]};
		tk();
		log_rd_req.valid <= 1'b0;
		#1 chk("rd_valid", log_rd_rsp.valid, 1);
		chk("rd_data", log_rd_rsp.data, e);
	endtask
	task automatic app(int k);
		for (int i = 0; i < k; i++) begin
			tk();
			img[n] = $urandom;
			log_wr <= {1'b1, img[n]};
			n++;
		end
		tk();
		log_wr.valid <= 1'b0;
	endtask
	task automatic boot(logic wp, logic bp, logic e);
		rst_wait();
		tk();
		go <= 1;
		pec <= wp;
		bad <= bp;
		cmd <= c;
		tk();
		go <= 0;
		tk(4);
		#1 chk("boot", boot_mode, e);
		chk("seq", seq_enable, !e);
		chk("pec", pec_seen, e && wp);
	endtask
	initial begin
		void'($urandom(32'hfc7b));
		tk(8);
		rst_wait();
		app(1 + $urandom % 5);
		#1 chk("count", log_count, n);
		for (int i = 0; i < n; i++) rd(i, img[i]);
		rd(15, ERASED_WORD);
		rst_wait();
		chk("kept", log_erased, 0);
		rd(n - 1, img[n - 1]);
		$display("append and restart done");
		tk();
		log_wr <= {1'b1, 32'h0000_0000};
		sys_rst <= 1;
		tk();
		log_wr.valid <= 1'b0;
		rst_wait();
		chk("erased", log_erased, 1);
		chk("wait", w >= 20, 1);
		rd(0, ERASED_WORD);
		n = 0;
		app(16);
		#1 chk("full", log_wr_ready, 0);
		rd(15, img[15]);
		$display("erase and fill done");
		for (int i = 0; i < 4; i++) begin
			c = (i == 3) ? 8'($urandom) : BOOT_MODE_CODE;
			if (i == 3 && c == BOOT_MODE_CODE) c = 8'h00;
			boot(i % 3 != 0, i == 2, i < 2);
		end
		$display("boot command done");
		test_done();
	end
endmodule
